// ---- cst_exec.sv ----
// Execution slice: subtract, subtract with borrow, set carry, arithmetic shift,
// halt with key guard and the two mask tests, with an Avalon-MM register port.
// Assumes one clock, a wake pin from outside that clock, and a clock/reset unit
// that acts on the stop and program-counter outputs.
`timescale 1ns/100ps
`include "cst_params.svh"

module cst_exec #(
   parameter logic [7:0] WR_BASE = `CST_WR_BASE,
   parameter logic [15:0] RESET_VEC = `CST_RESET_VEC
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // External wake-up pin
   input wire logic ext_wake,
   // Clock and reset control
   output logic cpu_clk_stop,
   output logic sys_clk_stop,
   output logic pc_load,
   output logic [15:0] pc_load_addr,
   // Condition flags
   output cst_pkg::cst_flags_s flags
);

   // Subtraction by adding the complement of the source and of the borrow in.
   function automatic cst_pkg::cst_alu_s alu_sub(input logic [7:0] d, input logic [7:0] s, input logic cin);
      cst_pkg::cst_alu_s r;
      logic [8:0] t;
      t = {1'b0, d} + {1'b0, ~s} + {8'h00, ~cin};
      r.res = t[7:0];
      r.fl.c = ~t[8];
      r.fl.z = (t[7:0] == 8'h00);
      r.fl.s = t[7];
      r.fl.v = (d[7] ^ s[7]) & (t[7] == s[7]);
      return r;
   endfunction

   // Operand forms, addresses, lengths and cycle counts of one instruction.
   function automatic cst_pkg::cst_dec_s decode(input logic [7:0] opc, input logic [7:0] b1,
                                                input logic [7:0] b2);
      cst_pkg::cst_dec_s d;
      d = '0;
      d.op = cst_pkg::OP_NONE;
      d.nbytes = `CST_BYTES_1;
      d.ncyc = `CST_CYC_SHORT;
      if (opc == `CST_OP_HALT) begin
         d.op = cst_pkg::OP_HALT;
      end else if (opc == `CST_OP_SCF) begin
         d.op = cst_pkg::OP_SCF;
      end else if (opc == `CST_OP_SRA_R || opc == `CST_OP_SRA_IR) begin
         d.op = cst_pkg::OP_SRA;
         d.nbytes = `CST_BYTES_2;
         d.dst_ind = (opc == `CST_OP_SRA_IR);
         d.dst_addr = b1;
         d.ptr_addr = b1;
      end else begin
         case (opc[7:4])
            `CST_HI_SBC: begin
               d.op = cst_pkg::OP_SBC;
            end
            `CST_HI_SUB: begin
               d.op = cst_pkg::OP_SUB;
            end
            `CST_HI_TCM: begin
               d.op = cst_pkg::OP_TCM;
            end
            `CST_HI_TM: begin
               d.op = cst_pkg::OP_TM;
            end
            default: begin
               d.op = cst_pkg::OP_NONE;
            end
         endcase
         d.nbytes = `CST_BYTES_3;
         d.ncyc = `CST_CYC_LONG;
         case (opc[3:0])
            `CST_LO_RR: begin
               d.nbytes = `CST_BYTES_2;
               d.ncyc = `CST_CYC_SHORT;
               d.dst_addr = WR_BASE + {4'h0, b1[7:4]};
               d.src_addr = WR_BASE + {4'h0, b1[3:0]};
            end
            `CST_LO_RIR: begin
               d.nbytes = `CST_BYTES_2;
               d.dst_addr = WR_BASE + {4'h0, b1[7:4]};
               d.ptr_addr = WR_BASE + {4'h0, b1[3:0]};
               d.src_ind = 1'b1;
            end
            `CST_LO_RR_FILE: begin
               d.src_addr = b1;
               d.dst_addr = b2;
            end
            `CST_LO_RIR_FILE: begin
               d.ptr_addr = b1;
               d.src_ind = 1'b1;
               d.dst_addr = b2;
            end
            `CST_LO_RIM: begin
               d.dst_addr = b1;
               d.imm = 1'b1;
               d.imm_val = b2;
            end
            default: begin
               d.op = cst_pkg::OP_NONE;
            end
         endcase
      end
      return d;
   endfunction

   // Bus state.
   logic [1:0] phase, next_phase;
   logic [23:0] instr, next_instr;
   logic [7:0] key, next_key;
   logic [7:0] rf_addr, next_rf_addr;
   logic [31:0] next_readdata;
   logic req, wr_done, go_req, clr_rvt, clr_ill, wr_flags, rf_we;

   // Execution state.
   cst_pkg::cst_state_e state, next_state;
   cst_pkg::cst_dec_s dec, next_dec, d_new;
   cst_pkg::cst_flags_s next_flags;
   cst_pkg::cst_alu_s alu;
   logic [2:0] cnt, next_cnt;
   logic [7:0] opa, next_opa, dst_addr, next_dst_addr;
   logic rvt, next_rvt, ill, next_ill;
   logic [2:0] sync, next_sync;
   logic next_pc_load, next_stop, wake, busy;
   logic exec_we;
   logic [7:0] mem_raddr, mem_rdata;

   cst_regfile #(.AW(8), .DW(8)) u_rf (
      .clk(clk),
      .ce(ce),
      .we(exec_we | rf_we),
      .waddr(exec_we ? dst_addr : rf_addr),
      .wdata(exec_we ? alu.res : writedata[7:0]),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   assign busy = (state != cst_pkg::ST_IDLE) && (state != cst_pkg::ST_STOP);
   assign req = read | write;
   assign waitrequest = req & (phase != 2'd2);
   assign wr_done = write & (phase == 2'd2);
   assign go_req = wr_done && address == `CST_OFS_CTRL && byteenable[0] && writedata[`CST_BIT_GO];
   assign clr_rvt = wr_done && address == `CST_OFS_CTRL && byteenable[0] && writedata[`CST_BIT_RVT];
   assign clr_ill = wr_done && address == `CST_OFS_CTRL && byteenable[0] && writedata[`CST_BIT_ILL];
   assign wr_flags = wr_done && address == `CST_OFS_FLAGS && byteenable[0];
   assign rf_we = wr_done && address == `CST_OFS_RFDAT && byteenable[0];

   // Every access takes two wait cycles; register-file data wait until execution ends.
   always_comb begin
      next_phase = 2'd0;
      next_instr = instr;
      next_key = key;
      next_rf_addr = rf_addr;
      next_readdata = readdata;
      if (req) begin
         case (phase)
            2'd0: begin
               next_phase = (address == `CST_OFS_RFDAT && busy) ? 2'd0 : 2'd1;
            end
            2'd1: begin
               next_phase = 2'd2;
            end
            default: begin
               next_phase = 2'd0;
            end
         endcase
      end
      if (read && phase == 2'd1) begin
         case (address)
            `CST_OFS_CTRL: begin
               next_readdata = {28'h0000000, ill, rvt, state == cst_pkg::ST_STOP, busy};
            end
            `CST_OFS_INSTR: begin
               next_readdata = {8'h00, instr};
            end
            `CST_OFS_FLAGS: begin
               next_readdata = {24'h000000, flags, 4'h0};
            end
            `CST_OFS_KEY: begin
               next_readdata = {24'h000000, key};
            end
            `CST_OFS_RFADR: begin
               next_readdata = {24'h000000, rf_addr};
            end
            `CST_OFS_RFDAT: begin
               next_readdata = {24'h000000, mem_rdata};
            end
            `CST_OFS_INFO: begin
               next_readdata = {24'h000000, 1'b0, dec.ncyc, 2'b00, dec.nbytes};
            end
            default: begin
               next_readdata = 32'h00000000;
            end
         endcase
      end
      if (wr_done && address == `CST_OFS_INSTR) begin
         if (byteenable[0]) begin
            next_instr[7:0] = writedata[7:0];
         end
         if (byteenable[1]) begin
            next_instr[15:8] = writedata[15:8];
         end
         if (byteenable[2]) begin
            next_instr[23:16] = writedata[23:16];
         end
      end
      if (wr_done && address == `CST_OFS_KEY && byteenable[0]) begin
         next_key = writedata[7:0];
      end
      if (wr_done && address == `CST_OFS_RFADR && byteenable[0]) begin
         next_rf_addr = writedata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= 2'd0;
         instr <= `CST_RST_INSTR;
         key <= `CST_RST_KEY;
         rf_addr <= `CST_RST_RFADR;
         readdata <= 32'h00000000;
      end else if (ce) begin
         phase <= next_phase;
         instr <= next_instr;
         key <= next_key;
         rf_addr <= next_rf_addr;
         readdata <= next_readdata;
      end
   end

   assign wake = sync[1] & ~sync[2];
   assign d_new = decode(instr[7:0], instr[15:8], instr[23:16]);

   // Result and flags of the executing instruction; the destination is in mem_rdata.
   always_comb begin
      alu.res = 8'h00;
      alu.fl = flags;
      case (dec.op)
         cst_pkg::OP_SBC: begin
            alu = alu_sub(mem_rdata, opa, flags.c);
         end
         cst_pkg::OP_SUB: begin
            alu = alu_sub(mem_rdata, opa, 1'b0);
         end
         cst_pkg::OP_TCM: begin
            alu.res = ~mem_rdata & opa;
            alu.fl = '{c: flags.c, z: (alu.res == 8'h00), s: alu.res[7], v: 1'b0};
         end
         cst_pkg::OP_TM: begin
            alu.res = mem_rdata & opa;
            alu.fl = '{c: flags.c, z: (alu.res == 8'h00), s: alu.res[7], v: 1'b0};
         end
         cst_pkg::OP_SRA: begin
            alu.res = {mem_rdata[7], mem_rdata[7:1]};
            alu.fl = '{c: mem_rdata[0], z: (alu.res == 8'h00), s: alu.res[7], v: 1'b0};
         end
         default: begin
            alu.res = 8'h00;
         end
      endcase
   end

   always_comb begin
      next_state = state;
      next_dec = dec;
      next_cnt = cnt + 3'd1;
      next_opa = opa;
      next_dst_addr = dst_addr;
      next_flags = flags;
      next_sync = {sync[1:0], ext_wake};
      next_pc_load = 1'b0;
      next_rvt = rvt & ~clr_rvt;
      next_ill = ill & ~clr_ill;
      mem_raddr = rf_addr;
      exec_we = 1'b0;
      if (wr_flags) begin
         next_flags = '{c: writedata[`CST_BIT_C], z: writedata[`CST_BIT_Z],
                        s: writedata[`CST_BIT_S], v: writedata[`CST_BIT_V]};
      end
      case (state)
         cst_pkg::ST_IDLE: begin
            next_cnt = 3'd1;
            if (go_req) begin
               // Decode of opcode, length and cycles.
               next_dec = d_new;
               case (d_new.op)
                  cst_pkg::OP_NONE: begin
                     next_ill = 1'b1;
                  end
                  cst_pkg::OP_HALT: begin
                     if (key == `CST_HALT_KEY) begin
                        next_state = cst_pkg::ST_STOP;
                     end else begin
                        // Wrong key jumps to reset address.
                        next_pc_load = 1'b1;
                        next_rvt = 1'b1;
                        next_state = cst_pkg::ST_HOLD;
                     end
                  end
                  cst_pkg::OP_SCF: begin
                     next_flags.c = 1'b1;
                     next_state = cst_pkg::ST_HOLD;
                  end
                  default: begin
                     // Pick the fetch path for the operand form.
                     if (d_new.src_ind || d_new.dst_ind) begin
                        next_state = cst_pkg::ST_PTR;
                     end else if (d_new.imm || d_new.op == cst_pkg::OP_SRA) begin
                        next_state = cst_pkg::ST_DST;
                     end else begin
                        next_state = cst_pkg::ST_SRC;
                     end
                  end
               endcase
            end
         end
         cst_pkg::ST_PTR: begin
            mem_raddr = dec.ptr_addr;
            next_state = (dec.op == cst_pkg::OP_SRA) ? cst_pkg::ST_DST : cst_pkg::ST_SRC;
         end
         cst_pkg::ST_SRC: begin
            // Indirect source follows the pointer just read.
            mem_raddr = dec.src_ind ? mem_rdata : dec.src_addr;
            next_state = cst_pkg::ST_DST;
         end
         cst_pkg::ST_DST: begin
            // Destination address and source value or immediate byte.
            mem_raddr = dec.dst_ind ? mem_rdata : dec.dst_addr;
            next_dst_addr = dec.dst_ind ? mem_rdata : dec.dst_addr;
            next_opa = dec.imm ? dec.imm_val : mem_rdata;
            next_state = cst_pkg::ST_EXE;
         end
         cst_pkg::ST_EXE: begin
            // Tests leave both operands in place.
            exec_we = (dec.op == cst_pkg::OP_SBC) || (dec.op == cst_pkg::OP_SUB) || (dec.op == cst_pkg::OP_SRA);
            next_flags = alu.fl;
            next_state = (cnt == dec.ncyc - 3'd1) ? cst_pkg::ST_IDLE : cst_pkg::ST_HOLD;
         end
         cst_pkg::ST_HOLD: begin
            // Hold until the documented cycle count ends.
            if (cnt == dec.ncyc - 3'd1) begin
               next_state = cst_pkg::ST_IDLE;
            end
         end
         cst_pkg::ST_STOP: begin
            // Only an external wake edge or reset leaves stop.
            if (wake) begin
               next_state = cst_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = cst_pkg::ST_IDLE;
         end
      endcase
      next_stop = (next_state == cst_pkg::ST_STOP);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= cst_pkg::ST_IDLE;
         dec <= '0;
         cnt <= 3'd0;
         opa <= 8'h00;
         dst_addr <= 8'h00;
         flags <= `CST_RST_FLAGS;
         sync <= 3'b000;
         pc_load <= 1'b0;
         rvt <= 1'b0;
         ill <= 1'b0;
         cpu_clk_stop <= 1'b0;
         sys_clk_stop <= 1'b0;
         pc_load_addr <= RESET_VEC;
      end else if (ce) begin
         state <= next_state;
         dec <= next_dec;
         cnt <= next_cnt;
         opa <= next_opa;
         dst_addr <= next_dst_addr;
         flags <= next_flags;
         sync <= next_sync;
         pc_load <= next_pc_load;
         rvt <= next_rvt;
         ill <= next_ill;
         cpu_clk_stop <= next_stop;
         sys_clk_stop <= next_stop;
         pc_load_addr <= RESET_VEC;
      end
   end

endmodule

// ---- cst_exec_chk.sv ----
// Concurrent checks on the ports of the execution slice, bound into cst_exec.
// Assumes the bench keeps ce high and all byte lanes enabled.
`timescale 1ns/100ps
module cst_exec_chk #(
   parameter logic [15:0] RESET_VEC = 16'h0000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic [7:0] address,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic waitrequest,
   // Wake pin, clock stops and program counter load
   input wire logic ext_wake,
   input wire logic cpu_clk_stop,
   input wire logic sys_clk_stop,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_addr,
   input wire cst_pkg::cst_flags_s flags
);
   logic [7:0] op;
   logic [7:0] key;
   logic [7:0] next_op;
   logic [7:0] next_key;
   logic wr_done;
   logic go;

   // Shadows of the opcode and key registers, so each start can be classified.
   always_comb begin
      wr_done = write && !waitrequest;
      go = wr_done && address[7:2] == 6'h00 && writedata[0];
      next_op = (wr_done && address[7:2] == 6'h01) ? writedata[7:0] : op;
      next_key = (wr_done && address[7:2] == 6'h03) ? writedata[7:0] : key;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op <= 8'h00;
         key <= 8'h00;
      end else begin
         op <= next_op;
         key <= next_key;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_stop_pair: assert property (cpu_clk_stop == sys_clk_stop)
      else $error("CPU and system clock stops differ");
   a_halt_enter: assert property (go && op == 8'h7F && key == 8'hA5 |-> ##[1:2] cpu_clk_stop)
      else $error("Halt with correct key did not stop");
   a_halt_flags: assert property (cpu_clk_stop && $past(cpu_clk_stop) |-> $stable(flags))
      else $error("Flags changed while stopped");
   a_stop_keep: assert property (cpu_clk_stop && !ext_wake && !$past(ext_wake) && !$past(ext_wake, 2)
      && !$past(ext_wake, 3) && !$past(ext_wake, 4) && !$past(ext_wake, 5) |=> cpu_clk_stop)
      else $error("Stop ended without wake or reset");
   a_wake_exit: assert property ($rose(ext_wake) && cpu_clk_stop |-> ##[1:6] !cpu_clk_stop)
      else $error("Wake pin did not end stop");
   a_bad_key: assert property (go && op == 8'h7F && key != 8'hA5 |-> ##[1:2] (pc_load && !cpu_clk_stop))
      else $error("Halt with wrong key did not load the program counter");
   a_pc_vector: assert property (pc_load |-> pc_load_addr == RESET_VEC ##1 !pc_load)
      else $error("Program counter load address or pulse length wrong");
   a_scf_carry: assert property (go && op == 8'hDF |-> ##4 flags == ($past(flags, 4) | 4'h8))
      else $error("Set carry changed other flags or left carry low");
   a_sra_ovf: assert property (go && op[7:1] == 7'h68 |-> ##4 !flags.v)
      else $error("Shift right overflow set");
   a_test_carry: assert property (go && op[7:5] == 3'h3 && op[3:0] inside {[4'h2:4'h6]}
      |-> ##6 flags.c == $past(flags.c, 6) && !flags.v)
      else $error("Mask test touched carry or left overflow set");
endmodule

bind cst_exec cst_exec_chk #(.RESET_VEC(RESET_VEC)) u_chk (.clk(clk), .rst(rst), .address(address),
   .write(write), .writedata(writedata), .waitrequest(waitrequest), .ext_wake(ext_wake),
   .cpu_clk_stop(cpu_clk_stop), .sys_clk_stop(sys_clk_stop), .pc_load(pc_load),
   .pc_load_addr(pc_load_addr), .flags(flags));

// ---- cst_exec_tb.sv ----
// Self-checking bench for cst_exec: bus tasks, reference results, halt and wake.
// Assumes default parameters and the checker bound in beside the design.
`timescale 1ns/100ps
module cst_exec_tb;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0, ext_wake = 1'b0;
   logic [7:0] address = 8'h00, d, s, f;
   logic [31:0] writedata = 32'h0, readdata, r;
   logic [3:0] byteenable = 4'hF;
   logic waitrequest, cpu_clk_stop, sys_clk_stop, pc_load;
   logic [15:0] pc_load_addr, seed = 16'd23;
   cst_pkg::cst_flags_s flags, f0;
   int n_fail = 0, checks = 0, cyc = 0, n_pcl = 0;
   logic [7:0] ops [23] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h62,
      8'h63, 8'h64, 8'h65, 8'h66, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'hD0, 8'hD1, 8'hDF};

   cst_exec dut_u (.clk(clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .ext_wake(ext_wake), .cpu_clk_stop(cpu_clk_stop), .sys_clk_stop(sys_clk_stop), .pc_load(pc_load),
      .pc_load_addr(pc_load_addr), .flags(flags));

   always #25 clk = ~clk;

   always @(posedge clk) begin
      cyc++;
      n_pcl += pc_load === 1'b1;
      if (cyc > 30000) begin
         n_fail++;
         finish_test();
      end
   end

   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction

   function automatic cst_pkg::cst_alu_s ref_op(input logic [7:0] op, input logic [7:0] a,
         input logic [7:0] b, input cst_pkg::cst_flags_s fi);
      logic [8:0] t;
      cst_pkg::cst_alu_s e;
      t = {1'b0, a} - {1'b0, b} - {8'h00, op[7:4] == 4'h3 && fi.c};
      e.res = t[7:0];
      e.fl = {t[8], t[7:0] == 8'h00, t[7], a[7] != b[7] && t[7] == b[7]};
      if (op[7:5] == 3'h3)
         e.res = (op[4] ? a : ~a) & b;
      if (op[7:4] == 4'hD)
         e.res = op[3:0] == 4'hF ? a : {a[7], a[7:1]};
      if (op[7:4] > 4'h3)
         e.fl = {op[7:4] == 4'hD ? a[0] : fi.c, e.res == 8'h00, e.res[7], 1'b0};
      if (op == 8'hDF)
         e.fl = fi | 4'h8;
      return e;
   endfunction

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Holds the request until waitrequest is sampled low at a rising edge, then releases it there.
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd);
      int n = 0;
      address <= a;
      writedata <= wd;
      read <= rd;
      write <= !rd;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 40) begin
         n++;
         @(posedge clk);
      end
      n_fail += n == 40;
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rf(input logic rd, input logic [7:0] a, input logic [7:0] wd);
      bus(1'b0, 8'h10, {24'h0, a});
      bus(rd, 8'h14, {24'h0, wd});
   endtask

   task automatic run_op(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b, input logic [3:0] fi);
      logic [3:0] lo;
      logic [7:0] da, sa, b2;
      cst_pkg::cst_alu_s e;
      int n = 0;
      lo = op[3:0];
      da = lo == 2 || lo == 3 ? 8'hC1 : 8'h20;
      sa = lo == 2 ? 8'hC2 : (lo == 3 || lo == 5 ? 8'h30 : 8'h21);
      b2 = lo == 2 || lo == 3 ? 8'h12 : (lo == 4 ? 8'h21 : (lo == 6 || lo == 0 ? 8'h20 : 8'h22));
      if (lo == 3)
         rf(1'b0, 8'hC2, 8'h30);
      if (lo == 5 || lo == 1)
         rf(1'b0, 8'h22, lo == 1 ? 8'h20 : 8'h30);
      rf(1'b0, da, a);
      rf(1'b0, sa, b);
      bus(1'b0, 8'h08, {24'h0, fi, 4'h0});
      bus(1'b0, 8'h04, {8'h00, lo == 6 ? b : 8'h20, b2, op});
      bus(1'b0, 8'h00, 32'h1);
      r = 32'h1;
      while (r[0] !== 1'b0 && n < 20) begin
         n++;
         bus(1'b1, 8'h00, 32'h0);
      end
      n_fail += n == 20;
      e = ref_op(op, a, b, fi);
      bus(1'b1, 8'h08, 32'h0);
      cmp("flags", {24'h0, e.fl, 4'h0}, r);
      rf(1'b1, da, 8'h00);
      cmp("destination", {24'h0, op[7:4] < 4'h6 || op[7:1] == 7'h68 ? e.res : a}, r);
      rf(1'b1, sa, 8'h00);
      cmp("source", {24'h0, b}, r);
      bus(1'b1, 8'h18, 32'h0);
      cmp("length", {25'h0, lo == 3 || lo == 4 || lo == 5 || lo == 6 ? 3'd6 : 3'd4, 2'b0,
         op == 8'hDF ? 2'd1 : (lo < 4 ? 2'd2 : 2'd3)}, r);
   endtask

   task automatic regs_zero();
      bus(1'b0, 8'h1C, 32'hFFFFFFFF);
      foreach (ops[k])
         if (k < 6) begin
            bus(1'b1, k == 5 ? 8'h1C : 8'(k * 4), 32'h0);
            cmp("reset register", 32'h0, r);
         end
   endtask

   task automatic halt(input logic [7:0] k);
      f0 = flags;
      bus(1'b0, 8'h0C, {24'h0, k});
      bus(1'b0, 8'h04, 32'h7F);
      bus(1'b0, 8'h00, 32'h1);
      repeat (8) @(posedge clk);
   endtask

   task automatic finish_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      regs_zero();
      bus(1'b0, 8'h04, 32'h00000001);
      bus(1'b0, 8'h00, 32'h00000001);
      bus(1'b1, 8'h00, 32'h00000000);
      cmp("illegal status", 32'h00000008, r);
      bus(1'b0, 8'h00, 32'h00000008);
      bus(1'b1, 8'h00, 32'h00000000);
      cmp("illegal clear", 32'h00000000, r);
      run_op(8'h36, 8'h20, 8'h8A, 4'h8);
      run_op(8'h32, 8'h00, 8'h00, 4'h8);
      run_op(8'h22, 8'h55, 8'h55, 4'hF);
      run_op(8'h26, 8'h21, 8'h90, 4'h0);
      run_op(8'hD0, 8'h9A, 8'h00, 4'h8);
      run_op(8'h66, 8'hFF, 8'hFF, 4'h8);
      run_op(8'h76, 8'h2B, 8'h54, 4'hF);
      foreach (ops[k])
         repeat (3) begin
            d = rnd();
            s = rnd();
            f = rnd();
            run_op(ops[k], d, s, f[7:4]);
         end
      halt(8'hA5);
      cmp("stopped", {2'b11, f0}, {cpu_clk_stop, sys_clk_stop, flags});
      ext_wake <= 1'b1;
      repeat (8) @(posedge clk);
      cmp("woken", 2'b00, {cpu_clk_stop, sys_clk_stop});
      @(posedge clk);
      ext_wake <= 1'b0;
      bus(1'b1, 8'h00, 32'h0);
      cmp("stop status", 32'h0, r & 32'h3);
      halt(8'h5A);
      cmp("wrong key", {16'h0000, 2'b00, 14'd1}, {pc_load_addr, cpu_clk_stop, sys_clk_stop, 14'(n_pcl)});
      bus(1'b1, 8'h00, 32'h0);
      cmp("vector status", 32'h4, r & 32'h6);
      halt(8'hA5);
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cmp("reset exit", 2'b00, {cpu_clk_stop, sys_clk_stop});
      regs_zero();
      finish_test();
   end
endmodule

// ---- cst_params.svh ----
// Constants of the subtract, shift and mask-test execution slice.
// Included by the slice alone; holds definitions only.
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH

// Register word offsets on the Avalon-MM slave, as byte addresses.
`define CST_OFS_CTRL 8'h00
`define CST_OFS_INSTR 8'h04
`define CST_OFS_FLAGS 8'h08
`define CST_OFS_KEY 8'h0C
`define CST_OFS_RFADR 8'h10
`define CST_OFS_RFDAT 8'h14
`define CST_OFS_INFO 8'h18

// Control and status bit positions.
`define CST_BIT_GO 0
`define CST_BIT_BUSY 0
`define CST_BIT_STOP 1
`define CST_BIT_RVT 2
`define CST_BIT_ILL 3

// Flag bit positions in the flag register.
`define CST_BIT_C 7
`define CST_BIT_Z 6
`define CST_BIT_S 5
`define CST_BIT_V 4

// Reset values and the working-register base.
`define CST_RST_KEY 8'h00
`define CST_RST_FLAGS 4'h0
`define CST_RST_INSTR 24'h000000
`define CST_RST_RFADR 8'h00
`define CST_WR_BASE 8'hC0
`define CST_RESET_VEC 16'h0000

// Opcodes and opcode fields.
`define CST_HI_SUB 4'h2
`define CST_HI_SBC 4'h3
`define CST_HI_TCM 4'h6
`define CST_HI_TM 4'h7
`define CST_LO_RR 4'h2
`define CST_LO_RIR 4'h3
`define CST_LO_RR_FILE 4'h4
`define CST_LO_RIR_FILE 4'h5
`define CST_LO_RIM 4'h6
`define CST_OP_SRA_R 8'hD0
`define CST_OP_SRA_IR 8'hD1
`define CST_OP_SCF 8'hDF
`define CST_OP_HALT 8'h7F
`define CST_HALT_KEY 8'hA5

// Instruction lengths in bytes and execution times in cycles.
`define CST_BYTES_1 2'd1
`define CST_BYTES_2 2'd2
`define CST_BYTES_3 2'd3
`define CST_CYC_SHORT 3'd4
`define CST_CYC_LONG 3'd6

`endif

// ---- cst_pkg.sv ----
// Types shared by the execution slice, its checker and its bench.
// Constants live in cst_params.svh.
package cst_pkg;

   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
   } cst_flags_s;

   typedef struct packed {
      logic [7:0] res;
      cst_flags_s fl;
   } cst_alu_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PTR = 3'b001,
      ST_SRC = 3'b010,
      ST_DST = 3'b011,
      ST_EXE = 3'b100,
      ST_HOLD = 3'b101,
      ST_STOP = 3'b110
   } cst_state_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_SBC = 3'b001,
      OP_SUB = 3'b010,
      OP_TCM = 3'b011,
      OP_TM = 3'b100,
      OP_SRA = 3'b101,
      OP_SCF = 3'b110,
      OP_HALT = 3'b111
   } cst_op_e;

   typedef struct packed {
      cst_op_e op;
      logic src_ind;
      logic dst_ind;
      logic imm;
      logic [7:0] imm_val;
      logic [7:0] ptr_addr;
      logic [7:0] src_addr;
      logic [7:0] dst_addr;
      logic [1:0] nbytes;
      logic [2:0] ncyc;
   } cst_dec_s;

endpackage

// ---- cst_regfile.sv ----
// Byte-wide register file with one write port and one registered read port.
// Read data appear one enabled clock edge after the read address.
`timescale 1ns/100ps
module cst_regfile #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // Clock and enable
   input wire logic clk,
   input wire logic ce,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end

endmodule
